/* File: tb/spr_ramp_model.sv */
// Behavioural ramp generator facing the stall supervisor; current and bus voltage come from the bench.
// Assumes one clock shared with the supervisor; frequency in 0.01 Hz steps.
`timescale 1ns/100ps
`default_nettype none
module spr_ramp_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Supervisor command and target
   input wire spr_pkg::spr_ramp_cmd_t ramp_cmd,
   input wire logic [15:0] f_target,
   // Ramp state
   output logic [15:0] fout,
   output spr_pkg::spr_ramp_t ramp
);
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fout <= 16'h0000;
         ramp <= spr_pkg::RAMP_STOP;
      end else if (ramp_cmd.hold) begin
         fout <= fout;
      end else if (ramp_cmd.force_dec) begin
         // Later decel slots ramp faster here
         fout <= fout - {14'h0000, ramp_cmd.dec_sel} - 16'h0001;
         ramp <= spr_pkg::RAMP_DECEL;
      end else if (fout + 16'h0008 <= f_target) begin
         fout <= fout + 16'h0008;
         ramp <= spr_pkg::RAMP_ACCEL;
      end else if (fout >= f_target + 16'h0008) begin
         fout <= fout - 16'h0008;
         ramp <= spr_pkg::RAMP_DECEL;
      end else begin
         fout <= f_target;
         ramp <= (f_target == 16'h0000) ? spr_pkg::RAMP_STOP : spr_pkg::RAMP_CONST;
      end
   end
endmodule
`default_nettype wire

/* File: tb/spr_stall_ctrl_bench.sv */
// Self-checking bench for the stall prevention supervisor.
// Assumes the ramp model closes the loop; expected results queue to a monitor.
`timescale 1ns/100ps
`default_nettype none
module spr_stall_ctrl_bench;
   localparam int unsigned REC = 20;
   localparam spr_pkg::spr_cfg_t CFG_DEF = '{spr_pkg::ACC_EN_RST, 8'h64, spr_pkg::ACC_FLOOR_RST,
      spr_pkg::DEC_EN_RST, spr_pkg::DEC_LVL_RST, 1'b0, spr_pkg::RUN_SEL_RST, spr_pkg::RUN_LVL_RST,
      5'h00, spr_pkg::CM_OL_VF};
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] cur = 8'h00;
   logic [9:0] vbus = 10'h000;
   logic [15:0] fbase = 16'h1388;
   logic [15:0] f_target = 16'h0000;
   logic [7:0] analog_level_input = 8'h00;
   logic [1:0] active_decel_sel = 2'h0;
   spr_pkg::spr_cfg_t cfg = CFG_DEF;
   logic [15:0] fout;
   spr_pkg::spr_ramp_t ramp;
   spr_pkg::spr_ramp_cmd_t ramp_cmd;
   spr_pkg::spr_stat_t stall_status;
   wire spr_pkg::spr_meas_t meas = {cur, vbus, fout, fbase, ramp};
   // Hold, force, slot (only while forcing), acc, dec, run
   wire logic [6:0] seen = {ramp_cmd.hold, ramp_cmd.force_dec,
      ramp_cmd.force_dec ? ramp_cmd.dec_sel : 2'h0, stall_status};
   logic [6:0] exp_q[$];
   logic smp = 1'b0;
   int mismatches = 0;
   int checks_done = 0;

   spr_stall_ctrl #(.RECOVER_CYC(REC)) i_dut (.mclk(mclk), .sys_rst(sys_rst), .meas(meas),
      .analog_level_input(analog_level_input), .active_decel_sel(active_decel_sel), .cfg(cfg),
      .ramp_cmd(ramp_cmd), .stall_status(stall_status));
   spr_ramp_model i_ramp (.mclk(mclk), .sys_rst(sys_rst), .ramp_cmd(ramp_cmd),
      .f_target(f_target), .fout(fout), .ramp(ramp));

   initial begin
      forever #25 mclk = ~mclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [6:0] s, input logic [6:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR at %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic note(input logic [6:0] e);
      exp_q.push_back(e);
      smp = 1'b1;
      cyc(1);
      smp = 1'b0;
   endtask

   always @(negedge mclk) begin
      if (smp && exp_q.size() > 0)
         chk(seen, exp_q.pop_front());
   end

   task automatic rst();
      sys_rst <= 1'b1;
      cyc(16);
      sys_rst <= 1'b0;
      cyc(1);
   endtask

   // Bounded wait for the ramp model to settle or pass a frequency
   task automatic wait_for(input logic want_const, input logic [15:0] lim);
      int k;
      k = 0;
      while (k < 2000 && (want_const ? ramp !== spr_pkg::RAMP_CONST : !(fout > lim))) begin
         cyc(1);
         k++;
      end
      if (k == 2000) begin
         mismatches++;
         test_done();
      end
   endtask

   initial begin
      int m;
      logic [1:0] s;
      logic [9:0] lvl;
      void'($urandom(88));
      rst();
      // Acceleration halt and hysteresis
      f_target <= 16'h0BB8;
      cur <= 8'h65 + 8'($urandom % 40);
      cyc(3);
      note(7'h44);
      cur <= 8'h55;
      cyc(3);
      note(7'h44);
      cur <= 8'h54;
      cyc(3);
      note(7'h00);
      cfg.accel_stall_enable <= 1'b0;
      cur <= 8'h96;
      cyc(3);
      note(7'h00);
      cfg <= CFG_DEF;
      cfg.accel_stall_current_level <= 8'hC8;
      cur <= 8'h97;
      cyc(3);
      note(7'h44);
      // Derated level above base frequency
      rst();
      cfg <= CFG_DEF;
      fbase <= 16'h03E8;
      f_target <= 16'h1770;
      cur <= 8'h28;
      wait_for(1'b0, 16'h07D0);
      cur <= 8'h3C;
      cyc(3);
      note(7'h44);
      cur <= 8'h24;
      cyc(3);
      note(7'h44);
      cur <= 8'h22;
      cyc(3);
      note(7'h00);
      // Deceleration pause, both voltage classes, repeated
      rst();
      fbase <= 16'h1388;
      f_target <= 16'h0BB8;
      cur <= 8'h32;
      wait_for(1'b1, 16'h0000);
      f_target <= 16'h03E8;
      for (int cl = 0; cl < 2; cl++) begin
         lvl = (cl == 1) ? 10'h316 : 10'h18B;
         cfg.class_400v <= cl[0];
         vbus <= lvl + 10'h001;
         cyc(3);
         note(7'h42);
         vbus <= lvl;
         cyc(3);
         note(7'h42);
         vbus <= lvl - 10'h001;
         cyc(3);
         note(7'h00);
      end
      cfg.decel_stall_enable <= 1'b0;
      vbus <= 10'h3FF;
      cyc(3);
      note(7'h00);
      vbus <= 10'h12C;
      // Run stall over every method, then the second decel slot
      for (int i = 0; i < 6; i++) begin
         m = (i < 5) ? i : 0;
         rst();
         cfg <= CFG_DEF;
         cfg.method <= spr_pkg::spr_ctrl_t'(m[2:0]);
         cfg.run_stall_select <= (i == 5) ? spr_pkg::RUN_SEL_DT2 : spr_pkg::RUN_SEL_RST;
         f_target <= 16'h0BB8;
         cur <= 8'h32;
         wait_for(1'b1, 16'h0000);
         s = 2'($urandom);
         active_decel_sel <= s;
         cur <= 8'h97 + 8'($urandom % 50);
         cyc(3);
         if (m == 2 || m == 3) begin
            note(7'h00);
         end else begin
            note({2'b01, (i == 5) ? spr_pkg::DSEL_SECOND : s, 3'b001});
            cur <= 8'h94;
            cyc(REC + 5);
            note(7'h41);
            cur <= 8'h64;
            cyc(3);
            note(7'h41);
            cyc(REC - 8);
            note(7'h41);
            cyc(10);
            note(7'h00);
         end
      end
      // Low frequency inhibit, analog limit, level clamp, selector off
      rst();
      cfg <= CFG_DEF;
      f_target <= 16'h01F4;
      cur <= 8'h32;
      wait_for(1'b1, 16'h0000);
      cur <= 8'hC8;
      cyc(3);
      note(7'h00);
      cur <= 8'h32;
      f_target <= 16'h0BB8;
      // Let the ramp leave the constant state before waiting on it
      cyc(2);
      wait_for(1'b1, 16'h0000);
      cfg.analog_input_function_select <= spr_pkg::AIN_FUNC_RUN_LVL;
      analog_level_input <= 8'h3C;
      active_decel_sel <= 2'h2;
      cur <= 8'h46;
      cyc(3);
      note(7'h31);
      cfg.analog_input_function_select <= 5'h00;
      cfg.run_stall_current_level <= 8'h0A;
      cur <= 8'h19;
      cyc(3);
      note(7'h41);
      cfg.run_stall_select <= spr_pkg::RUN_SEL_OFF;
      // Released ramp re-accelerates; keep the accel halt out of this check
      cfg.accel_stall_enable <= 1'b0;
      cur <= 8'hC8;
      cyc(3);
      note(7'h00);
      cyc(2);
      test_done();
   end
endmodule
`default_nettype wire

/* File: verilog/spr_cp_level.sv */
// Constant power derating of the acceleration stall level.
// Assumes frequencies share one scale; result is registered.
`timescale 1ns/100ps
`default_nettype none
module spr_cp_level (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Settings and frequencies
   input wire logic [7:0] level,
   input wire logic [7:0] floor_lvl,
   input wire logic [15:0] fout,
   input wire logic [15:0] fbase,
   // Effective level
   output logic [7:0] level_eff
);

   logic [7:0] level_eff_reg;
   logic [7:0] level_eff_next;
   wire logic above_base = (fout > fbase) && (fout != 16'h0000);
   wire logic [23:0] prod = {16'h0000, level} * {8'h00, fbase};
   wire logic [23:0] quot = above_base ? prod / {8'h00, fout} : {16'h0000, level};
   wire logic [7:0] scaled = quot[7:0];

   // Scale by base over output above base frequency, never under the floor
   assign level_eff_next = (scaled < floor_lvl) ? floor_lvl : scaled;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         level_eff_reg <= spr_pkg::ACC_LVL_MAX;
      end else begin
         level_eff_reg <= level_eff_next;
      end
   end

   assign level_eff = level_eff_reg;

endmodule
`default_nettype wire

/* File: verilog/spr_pkg.sv */
// Shared constants and types for the stall prevention supervisor.
// Assumes measurements arrive already scaled: current in percent of rated,
// bus voltage in volts, frequency in 0.01 Hz steps.
package spr_pkg;

   // Timing
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned RUN_RECOVER_MS = 100;
   localparam int unsigned RUN_RECOVER_CYC = CLK_HZ / 1000 * RUN_RECOVER_MS;

   // Acceleration stall limits, percent
   localparam logic [7:0] ACC_LVL_MAX = 8'h96;
   localparam logic [7:0] ACC_FLOOR_MAX = 8'h64;
   localparam logic [7:0] ACC_FLOOR_RST = 8'h32;
   localparam logic [8:0] ACC_HYST = 9'h00F;
   localparam logic ACC_EN_RST = 1'b1;

   // Deceleration stall limits, volts for the lower class
   localparam logic [9:0] DEC_LVL_MIN = 10'h14A;
   localparam logic [9:0] DEC_LVL_MAX = 10'h19A;
   localparam logic [9:0] DEC_LVL_RST = 10'h18B;
   localparam logic DEC_EN_RST = 1'b1;

   // Run stall limits
   localparam logic [7:0] RUN_LVL_MIN = 8'h1E;
   localparam logic [7:0] RUN_LVL_MAX = 8'h96;
   localparam logic [7:0] RUN_LVL_RST = 8'h96;
   localparam logic [8:0] RUN_HYST = 9'h002;
   localparam logic [15:0] RUN_MIN_FREQ = 16'h0258;
   localparam logic [1:0] RUN_SEL_RST = 2'h1;
   localparam logic [1:0] RUN_SEL_OFF = 2'h0;
   localparam logic [1:0] RUN_SEL_DT2 = 2'h2;
   localparam logic [1:0] DSEL_SECOND = 2'h1;
   localparam logic [4:0] AIN_FUNC_RUN_LVL = 5'h07;

   typedef enum logic [2:0] {
      CM_OL_VF  = 3'b000,
      CM_CL_VF  = 3'b001,
      CM_OL_VEC = 3'b010,
      CM_CL_VEC = 3'b011,
      CM_PM_OLV = 3'b100
   } spr_ctrl_t;

   typedef enum logic [1:0] {
      RAMP_STOP  = 2'b00,
      RAMP_ACCEL = 2'b01,
      RAMP_DECEL = 2'b10,
      RAMP_CONST = 2'b11
   } spr_ramp_t;

   typedef enum logic [1:0] {
      RUN_IDLE  = 2'b00,
      RUN_SLOW  = 2'b01,
      RUN_DWELL = 2'b10
   } spr_run_t;

   typedef struct packed {
      logic [7:0] cur;
      logic [9:0] vbus;
      logic [15:0] fout;
      logic [15:0] fbase;
      spr_ramp_t ramp;
   } spr_meas_t;

   typedef struct packed {
      logic accel_stall_enable;
      logic [7:0] accel_stall_current_level;
      logic [7:0] accel_stall_level_floor;
      logic decel_stall_enable;
      logic [9:0] decel_stall_voltage_level;
      logic class_400v;
      logic [1:0] run_stall_select;
      logic [7:0] run_stall_current_level;
      logic [4:0] analog_input_function_select;
      spr_ctrl_t method;
   } spr_cfg_t;

   typedef struct packed {
      logic hold;
      logic force_dec;
      logic [1:0] dec_sel;
   } spr_ramp_cmd_t;

   typedef struct packed {
      logic acc;
      logic dec;
      logic run;
   } spr_stat_t;

endpackage

/* File: verilog/spr_stall_ctrl.sv */
// Stall prevention supervisor: gates the frequency ramp on current and bus voltage.
// Assumes measurements and ramp state come from logic on mclk.
`timescale 1ns/100ps
`default_nettype none
module spr_stall_ctrl #(
   parameter int unsigned RECOVER_CYC = spr_pkg::RUN_RECOVER_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Measurements and ramp state
   input wire spr_pkg::spr_meas_t meas,
   input wire logic [7:0] analog_level_input,
   input wire logic [1:0] active_decel_sel,
   // Settings
   input wire spr_pkg::spr_cfg_t cfg,
   // Ramp generator command
   output spr_pkg::spr_ramp_cmd_t ramp_cmd,
   // Status
   output spr_pkg::spr_stat_t stall_status
);

   localparam int CNT_W = $clog2(RECOVER_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RECOVER_CYC - 1);

   // Settings clamped to their ranges
   wire logic [7:0] acc_lvl_c;
   wire logic [7:0] acc_floor_c;
   wire logic [9:0] dec_lvl_c;
   wire logic [10:0] dec_lvl_eff;
   wire logic [7:0] run_lvl_c;
   wire logic [7:0] run_lvl_eff;
   wire logic [1:0] run_sel_c;
   wire logic ain_sel;
   wire logic method_ok;
   wire logic run_allowed;

   assign acc_lvl_c = (cfg.accel_stall_current_level > spr_pkg::ACC_LVL_MAX) ?
      spr_pkg::ACC_LVL_MAX : cfg.accel_stall_current_level;
   assign acc_floor_c = (cfg.accel_stall_level_floor > spr_pkg::ACC_FLOOR_MAX) ?
      spr_pkg::ACC_FLOOR_MAX : cfg.accel_stall_level_floor;
   assign dec_lvl_c = (cfg.decel_stall_voltage_level < spr_pkg::DEC_LVL_MIN) ? spr_pkg::DEC_LVL_MIN :
      (cfg.decel_stall_voltage_level > spr_pkg::DEC_LVL_MAX) ? spr_pkg::DEC_LVL_MAX :
      cfg.decel_stall_voltage_level;
   assign dec_lvl_eff = cfg.class_400v ? {dec_lvl_c, 1'b0} : {1'b0, dec_lvl_c};
   assign run_lvl_c = (cfg.run_stall_current_level < spr_pkg::RUN_LVL_MIN) ? spr_pkg::RUN_LVL_MIN :
      (cfg.run_stall_current_level > spr_pkg::RUN_LVL_MAX) ? spr_pkg::RUN_LVL_MAX :
      cfg.run_stall_current_level;
   assign ain_sel = (cfg.analog_input_function_select == spr_pkg::AIN_FUNC_RUN_LVL);
   assign run_lvl_eff = (ain_sel && (analog_level_input < run_lvl_c)) ?
      analog_level_input : run_lvl_c;

   // Code 3 is out of range and behaves as the default mode
   assign run_sel_c = (cfg.run_stall_select == 2'h3) ? spr_pkg::RUN_SEL_RST : cfg.run_stall_select;

   assign method_ok = (cfg.method == spr_pkg::CM_OL_VF) ||
      (cfg.method == spr_pkg::CM_CL_VF) ||
      (cfg.method == spr_pkg::CM_PM_OLV);
   assign run_allowed = (run_sel_c != spr_pkg::RUN_SEL_OFF) && method_ok &&
      (meas.fout >= spr_pkg::RUN_MIN_FREQ);

   // Constant power derated acceleration level
   wire logic [7:0] acc_lvl_eff;

   spr_cp_level u_cp_level (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .level(acc_lvl_c),
      .floor_lvl(acc_floor_c),
      .fout(meas.fout),
      .fbase(meas.fbase),
      .level_eff(acc_lvl_eff)
   );

   // Acceleration stall
   logic acc_hold_reg;
   logic acc_hold_next;
   wire logic accel_over = meas.cur > acc_lvl_eff;
   wire logic accel_clear = ({1'b0, meas.cur} + spr_pkg::ACC_HYST) < {1'b0, acc_lvl_eff};
   wire logic accelerating = (meas.ramp == spr_pkg::RAMP_ACCEL);

   assign acc_hold_next = cfg.accel_stall_enable && accelerating &&
      (acc_hold_reg ? !accel_clear : accel_over);

   // Deceleration stall
   logic dec_hold_reg;
   logic dec_hold_next;
   wire logic [10:0] vbus_x = {1'b0, meas.vbus};
   wire logic decelerating = (meas.ramp == spr_pkg::RAMP_DECEL);

   assign dec_hold_next = cfg.decel_stall_enable && decelerating &&
      (dec_hold_reg ? !(vbus_x < dec_lvl_eff) : (vbus_x > dec_lvl_eff));

   // Run stall state machine
   spr_pkg::spr_run_t run_reg;
   spr_pkg::spr_run_t run_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   wire logic run_over = meas.cur > run_lvl_eff;
   wire logic run_low = ({1'b0, meas.cur} + spr_pkg::RUN_HYST) < {1'b0, run_lvl_eff};
   wire logic run_done = run_low && (cnt_reg == CNT_LAST);
   wire logic at_speed = (meas.ramp == spr_pkg::RAMP_CONST);

   always_comb begin
      run_next = run_reg;
      case (run_reg)
         spr_pkg::RUN_IDLE: begin
            if (run_allowed && at_speed && run_over) begin
               run_next = spr_pkg::RUN_SLOW;
            end
         end
         spr_pkg::RUN_SLOW: begin
            if (!run_allowed) begin
               run_next = spr_pkg::RUN_IDLE;
            end else if (!run_over) begin
               run_next = spr_pkg::RUN_DWELL;
            end
         end
         spr_pkg::RUN_DWELL: begin
            if (!run_allowed) begin
               run_next = spr_pkg::RUN_IDLE;
            end else if (run_over) begin
               run_next = spr_pkg::RUN_SLOW;
            end else if (run_done) begin
               run_next = spr_pkg::RUN_IDLE;
            end
         end
         default: begin
            run_next = spr_pkg::RUN_IDLE;
         end
      endcase
   end

   // Quiet time counter, restarts whenever current is not low enough
   assign cnt_next = (run_reg == spr_pkg::RUN_DWELL && run_low && !run_done) ?
      cnt_reg + CNT_W'(1) : '0;

   // Ramp command
   spr_pkg::spr_ramp_cmd_t cmd_reg;
   spr_pkg::spr_ramp_cmd_t cmd_next;
   spr_pkg::spr_stat_t stat_reg;
   spr_pkg::spr_stat_t stat_next;
   wire logic [1:0] dsel = (run_sel_c == spr_pkg::RUN_SEL_DT2) ?
      spr_pkg::DSEL_SECOND : active_decel_sel;

   assign cmd_next.hold = acc_hold_next || dec_hold_next || (run_next == spr_pkg::RUN_DWELL);
   assign cmd_next.force_dec = (run_next == spr_pkg::RUN_SLOW);
   assign cmd_next.dec_sel = dsel;
   assign stat_next.acc = acc_hold_next;
   assign stat_next.dec = dec_hold_next;
   assign stat_next.run = (run_next != spr_pkg::RUN_IDLE);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         acc_hold_reg <= 1'b0;
         dec_hold_reg <= 1'b0;
         run_reg <= spr_pkg::RUN_IDLE;
         cnt_reg <= '0;
         cmd_reg <= '0;
         stat_reg <= '0;
      end else begin
         acc_hold_reg <= acc_hold_next;
         dec_hold_reg <= dec_hold_next;
         run_reg <= run_next;
         cnt_reg <= cnt_next;
         cmd_reg <= cmd_next;
         stat_reg <= stat_next;
      end
   end

   assign ramp_cmd = cmd_reg;
   assign stall_status = stat_reg;

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   a_acc_off_free: assert property (
      !cfg.accel_stall_enable |=> !stall_status.acc)
      else $error("acceleration halted while disabled");

   a_acc_freeze: assert property (
      cfg.accel_stall_enable && accelerating && accel_over |=> ramp_cmd.hold && stall_status.acc)
      else $error("ramp not frozen on acceleration overcurrent");

   a_acc_hyst: assert property (
      acc_hold_reg && cfg.accel_stall_enable && accelerating && !accel_clear |=> acc_hold_reg)
      else $error("acceleration resumed inside hysteresis band");

   a_acc_level_range: assert property (
      acc_lvl_c <= spr_pkg::ACC_LVL_MAX && (acc_lvl_c == cfg.accel_stall_current_level
      || cfg.accel_stall_current_level > spr_pkg::ACC_LVL_MAX))
      else $error("acceleration level clamp wrong");

   a_acc_floor: assert property (
      ##1 acc_lvl_eff >= $past(acc_floor_c))
      else $error("derated level below floor");

   a_dec_off_plain: assert property (
      !cfg.decel_stall_enable |=> !dec_hold_reg && !stall_status.dec)
      else $error("deceleration paused while disabled");

   a_dec_pause: assert property (
      cfg.decel_stall_enable && decelerating && vbus_x > dec_lvl_eff |=> ramp_cmd.hold)
      else $error("deceleration not paused on high bus");

   a_dec_resume: assert property (
      dec_hold_reg && vbus_x < dec_lvl_eff |=> !dec_hold_reg)
      else $error("deceleration not resumed below level");

   a_dec_class: assert property (
      cfg.class_400v |-> dec_lvl_eff >= {spr_pkg::DEC_LVL_MIN, 1'b0}
      && dec_lvl_eff <= {spr_pkg::DEC_LVL_MAX, 1'b0})
      else $error("bus level not doubled for high class");

   a_run_off_idle: assert property (
      run_sel_c == spr_pkg::RUN_SEL_OFF |=> !ramp_cmd.force_dec && run_reg == spr_pkg::RUN_IDLE)
      else $error("run stall active while disabled");

   a_run_low_freq: assert property (
      meas.fout < spr_pkg::RUN_MIN_FREQ |=> run_reg == spr_pkg::RUN_IDLE)
      else $error("run stall active below minimum frequency");

   a_run_dsel: assert property (
      ramp_cmd.force_dec |-> ramp_cmd.dec_sel == $past(dsel))
      else $error("wrong deceleration time during run stall");

   a_run_recover: assert property (
      run_reg == spr_pkg::RUN_DWELL && run_allowed && !run_over && run_next == spr_pkg::RUN_IDLE
      |-> cnt_reg == CNT_LAST)
      else $error("run stall released before quiet time");

   a_run_mode2: assert property (
      ramp_cmd.force_dec && $past(run_sel_c) == spr_pkg::RUN_SEL_DT2
      |-> ramp_cmd.dec_sel == spr_pkg::DSEL_SECOND)
      else $error("mode 2 not using second deceleration time");

   a_run_level_range: assert property (
      run_lvl_c >= spr_pkg::RUN_LVL_MIN && run_lvl_c <= spr_pkg::RUN_LVL_MAX)
      else $error("run level out of range");

   a_run_analog_min: assert property (
      ain_sel |-> run_lvl_eff <= analog_level_input && run_lvl_eff <= run_lvl_c)
      else $error("analog run level not the smaller one");

   a_run_method: assert property (
      !method_ok |=> run_reg == spr_pkg::RUN_IDLE)
      else $error("run stall active under wrong control method");

   c_acc_halt: cover property (stall_status.acc ##1 !stall_status.acc && accelerating);
   c_dec_repeat: cover property (stall_status.dec ##1 !stall_status.dec ##[1:50] stall_status.dec);
   c_run_release: cover property (run_reg == spr_pkg::RUN_DWELL ##1 run_reg == spr_pkg::RUN_IDLE);
   c_run_mode2: cover property (ramp_cmd.force_dec && ramp_cmd.dec_sel == spr_pkg::DSEL_SECOND);

endmodule
`default_nettype wire
